// [uart_tx_pkg.sv]
/*
   Shared constants for the asynchronous serial transmitter: register
   offsets, bit positions, reset values, rate prescalers and shifter states.
   Assumes a classic Wishbone slave with 32-bit data and byte addresses.
*/
package uart_tx_pkg;

   // ----------------------------------------------------------------
   // Register map, byte offsets of aligned 32-bit words
   // ----------------------------------------------------------------
   localparam int ADDR_W = 6;
   localparam logic [5:0] HOLD_OFS = 6'h00;
   localparam logic [5:0] TSC_OFS = 6'h04;
   localparam logic [5:0] PORT_OFS = 6'h08;
   localparam logic [5:0] DIVL_OFS = 6'h0C;
   localparam logic [5:0] DIVH_OFS = 6'h10;
   localparam logic [5:0] IRQ_STAT_OFS = 6'h14;
   localparam logic [5:0] IRQ_CLR_OFS = 6'h18;
   localparam logic [5:0] IRQ_EN_OFS = 6'h1C;
   localparam logic [5:0] INTC_OFS = 6'h20;

   // ----------------------------------------------------------------
   // Field positions
   // ----------------------------------------------------------------
   localparam int TSC_NINE = 6;
   localparam int TSC_TRANSMIT_ENABLE_BIT = 5;
   localparam int TSC_CLOCKED = 4;
   localparam int TSC_HS = 2;
   localparam int TSC_EMPTY = 1;
   localparam int TSC_NINTH = 0;
   localparam int PORT_SERIAL_PORT_ENABLE = 7;
   localparam int PORT_INV = 4;
   localparam int PORT_WIDE = 3;
   localparam int INTC_GLOBAL = 7;
   localparam int INTC_PERIPH = 6;
   localparam int IRQ_BUF = 0;
   localparam int IRQ_DONE = 1;
   localparam int IRQ_W = 2;

   // ----------------------------------------------------------------
   // Reset values and rate prescalers
   // ----------------------------------------------------------------
   localparam logic [7:0] DIV_RESET = 8'h00;
   localparam logic [IRQ_W-1:0] IRQ_EN_RESET = 2'h0;
   localparam int PRE_NARROW = 64;
   localparam int PRE_WIDE = 16;

   typedef enum logic [1:0] {st_idle, st_start, st_data, st_stop} shift_state_t;

endpackage

// [baud_tick_gen.sv]
/*
   Bit-rate enable generator: one-cycle tick every prescale*(divisor+1)
   clocks. Assumes the divisor is stable while a character is on the line.
*/
`timescale 1ns/1ps
module baud_tick_gen
   import uart_tx_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic restart_i,
   input wire logic wide_i,
   input wire logic [15:0] divisor_i,
   output logic tick_o
);
   logic [5:0] pre_cnt;
   logic [15:0] div_cnt;
   logic pre_end;

   // The prescaler is 64 with the narrow divisor, 16 with the wide one.
   assign pre_end = wide_i ? (pre_cnt == 6'(PRE_WIDE - 1)) : (pre_cnt == 6'(PRE_NARROW - 1));

   // ----------------------------------------------------------------
   // Counters; restart aligns the first bit with the start of a frame
   // ----------------------------------------------------------------
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         pre_cnt <= 6'h00;
         div_cnt <= 16'h0000;
         tick_o <= 1'b0;
      end
      else if (restart_i)
      begin
         // The start bit already holds the line in the restart cycle, so that
         // cycle counts; otherwise the start bit would run one clock long.
         pre_cnt <= 6'h01;
         div_cnt <= 16'h0000;
         tick_o <= 1'b0;
      end
      else
      begin
         tick_o <= 1'b0;
         pre_cnt <= pre_end ? 6'h00 : pre_cnt + 6'h01;
         if (pre_end)
         begin
            if (div_cnt >= divisor_i)
            begin
               div_cnt <= 16'h0000;
               tick_o <= 1'b1;
            end
            else
               div_cnt <= div_cnt + 16'h0001;
         end
      end
   end
endmodule // baud_tick_gen

// [tx_frame_shifter.sv]
/*
   Frame shifter: start bit, 8 or 9 data bits LSB first, one stop bit,
   in normal polarity. Assumes load_i is a one-cycle pulse only while idle.
*/
`timescale 1ns/1ps
module tx_frame_shifter
   import uart_tx_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic load_i,
   input wire logic [8:0] data_i,
   input wire logic nine_i,
   input wire logic tick_i,
   output logic line_o,
   output logic busy_o,
   output logic done_o
);
   shift_state_t state;
   logic [8:0] transmit_shifter;
   logic [3:0] remaining;

   // ----------------------------------------------------------------
   // Frame sequencer, one bit per rate tick
   // ----------------------------------------------------------------
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         state <= st_idle;
         transmit_shifter <= 9'h000;
         remaining <= 4'h0;
         line_o <= 1'b1;
         busy_o <= 1'b0;
         done_o <= 1'b0;
      end
      else
      begin
         done_o <= 1'b0;
         case (state)
            st_idle:
               if (load_i)
               begin
                  transmit_shifter <= data_i;
                  remaining <= nine_i ? 4'h8 : 4'h7;
                  line_o <= 1'b0;
                  busy_o <= 1'b1;
                  state <= st_start;
               end
            st_start:
               if (tick_i)
               begin
                  line_o <= transmit_shifter[0];
                  transmit_shifter <= transmit_shifter >> 1;
                  state <= st_data;
               end
            st_data:
               if (tick_i)
               begin
                  if (remaining == 4'h0)
                  begin
                     line_o <= 1'b1;
                     state <= st_stop;
                  end
                  else
                  begin
                     line_o <= transmit_shifter[0];
                     transmit_shifter <= transmit_shifter >> 1;
                     remaining <= remaining - 4'h1;
                  end
               end
            st_stop:
               if (tick_i)
               begin
                  busy_o <= 1'b0;
                  done_o <= 1'b1;
                  state <= st_idle;
               end
            default:
               state <= st_idle;
         endcase
      end
   end
endmodule // tx_frame_shifter

// [async_serial_transmitter.sv]
/*
   Asynchronous serial transmitter with a Wishbone register file, holding
   register, frame shifter, rate generator and one level interrupt output.
   Assumes a classic Wishbone master on clk_i and a remote receiver on tx_o.
*/
`timescale 1ns/1ps
module async_serial_transmitter
   import uart_tx_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [ADDR_W-1:0] adr_i,
   input wire logic [3:0] sel_i,
   input wire logic [31:0] dat_i,
   output logic [31:0] dat_o,
   output logic ack_o,
   output logic tx_o,
   output logic irq_o
);
   // ----------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------
   logic nine_bit_enable;
   logic transmit_enable_bit;
   logic clocked_mode;
   logic high_speed_select;
   logic ninth_data_value;
   logic shifter_empty_flag;
   logic serial_port_enable;
   logic polarity_invert;
   logic wide_divisor_select;
   logic [7:0] rate_divisor_low;
   logic [7:0] rate_divisor_high;
   logic [7:0] transmit_holding_reg;
   logic holding_full;
   logic done_sticky;
   logic [IRQ_W-1:0] irq_enable;
   logic global_interrupt_enable;
   logic peripheral_interrupt_enable;
   logic tx_buffer_flag;
   logic [IRQ_W-1:0] irq_status;
   logic port_live;
   logic tx_run;
   logic transfer;
   logic [8:0] load_word;
   logic wr;
   logic wr_byte;
   logic rd;
   logic tick;
   logic line;
   logic sh_busy;
   logic sh_done;
   logic [31:0] next_rdata;

   // ----------------------------------------------------------------
   // Bus decode
   // ----------------------------------------------------------------
   // Writes take effect on the edge where the master sees ack high.
   assign rd = cyc_i && stb_i && !ack_o;
   assign wr = cyc_i && stb_i && we_i && ack_o;
   assign wr_byte = wr && sel_i[0];

   // Port is live only in asynchronous mode with the port enabled.
   assign port_live = serial_port_enable && !clocked_mode;
   assign tx_run = port_live && transmit_enable_bit;

   // Buffer flag tracks an empty holding register once sending is on.
   assign tx_buffer_flag = transmit_enable_bit && !holding_full;

   // A waiting character moves as soon as the shifter is free.
   assign transfer = holding_full && !sh_busy && tx_run;
   assign load_word = {nine_bit_enable & ninth_data_value, transmit_holding_reg};
   assign irq_status = {done_sticky, tx_buffer_flag};

   // ----------------------------------------------------------------
   // Bus handshake: one wait cycle, ack for exactly one cycle
   // ----------------------------------------------------------------
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         ack_o <= 1'b0;
      else
         ack_o <= cyc_i && stb_i && !ack_o;
   end

   // Read mux; the shifter has no address, unmapped words read zero.
   always_comb
   begin
      next_rdata = 32'h0000_0000;
      case (adr_i)
         TSC_OFS:
            next_rdata[7:0] = {1'b0, nine_bit_enable, transmit_enable_bit,
               clocked_mode, 1'b0, high_speed_select, shifter_empty_flag,
               ninth_data_value};
         PORT_OFS:
            next_rdata[7:0] = {serial_port_enable, 2'b00, polarity_invert,
               wide_divisor_select, 3'b000};
         DIVL_OFS: next_rdata[7:0] = rate_divisor_low;
         DIVH_OFS: next_rdata[7:0] = rate_divisor_high;
         IRQ_STAT_OFS: next_rdata[IRQ_W-1:0] = irq_status;
         IRQ_EN_OFS: next_rdata[IRQ_W-1:0] = irq_enable;
         INTC_OFS: next_rdata[7:0] = {global_interrupt_enable,
            peripheral_interrupt_enable, 6'b000000};
         default: next_rdata = 32'h0000_0000;
      endcase
   end

   // Read data is captured with the ack so it stands while ack is high.
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         dat_o <= 32'h0000_0000;
      else if (rd)
         dat_o <= next_rdata;
      else
         dat_o <= 32'h0000_0000;
   end

   // ----------------------------------------------------------------
   // Control registers
   // ----------------------------------------------------------------
   // Divisor and selects are software's to set before enabling.
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         nine_bit_enable <= 1'b0;
         transmit_enable_bit <= 1'b0;
         clocked_mode <= 1'b0;
         high_speed_select <= 1'b0;
         ninth_data_value <= 1'b0;
         serial_port_enable <= 1'b0;
         polarity_invert <= 1'b0;
         wide_divisor_select <= 1'b0;
         rate_divisor_low <= DIV_RESET;
         rate_divisor_high <= DIV_RESET;
      end
      else if (wr_byte)
      begin
         case (adr_i)
            TSC_OFS:
            begin
               nine_bit_enable <= dat_i[TSC_NINE];
               transmit_enable_bit <= dat_i[TSC_TRANSMIT_ENABLE_BIT];
               clocked_mode <= dat_i[TSC_CLOCKED];
               high_speed_select <= dat_i[TSC_HS];
               ninth_data_value <= dat_i[TSC_NINTH];
            end
            PORT_OFS:
            begin
               serial_port_enable <= dat_i[PORT_SERIAL_PORT_ENABLE];
               polarity_invert <= dat_i[PORT_INV];
               wide_divisor_select <= dat_i[PORT_WIDE];
            end
            DIVL_OFS: rate_divisor_low <= dat_i[7:0];
            DIVH_OFS: rate_divisor_high <= dat_i[7:0];
            default: ;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Holding register
   // ----------------------------------------------------------------
   // A write while sending is off or the register is full is dropped,
   // so a character already waiting is never overwritten.
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         transmit_holding_reg <= 8'h00;
         holding_full <= 1'b0;
      end
      else if (wr_byte && adr_i == HOLD_OFS && tx_run && !holding_full)
      begin
         transmit_holding_reg <= dat_i[7:0];
         holding_full <= 1'b1;
      end
      else if (transfer)
         holding_full <= 1'b0;
   end

   // Shifter-empty flag: cleared by the move, set once the stop bit ends with no character waiting.
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         shifter_empty_flag <= 1'b1;
      else if (transfer)
         shifter_empty_flag <= 1'b0;
      else if (sh_done)
         shifter_empty_flag <= 1'b1;
   end

   // ----------------------------------------------------------------
   // Interrupts
   // ----------------------------------------------------------------
   // Frame-done is sticky; a new frame end wins over a clear.
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         done_sticky <= 1'b0;
      else if (sh_done)
         done_sticky <= 1'b1;
      else if (wr_byte && adr_i == IRQ_CLR_OFS && dat_i[IRQ_DONE])
         done_sticky <= 1'b0;
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         irq_enable <= IRQ_EN_RESET;
         global_interrupt_enable <= 1'b0;
         peripheral_interrupt_enable <= 1'b0;
      end
      else if (wr_byte && adr_i == IRQ_EN_OFS)
         irq_enable <= dat_i[IRQ_W-1:0];
      else if (wr_byte && adr_i == INTC_OFS)
      begin
         global_interrupt_enable <= dat_i[INTC_GLOBAL];
         peripheral_interrupt_enable <= dat_i[INTC_PERIPH];
      end
   end

   // The shifter-empty flag is deliberately not an interrupt source.
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         irq_o <= 1'b0;
      else
         irq_o <= global_interrupt_enable && peripheral_interrupt_enable
            && |(irq_status & irq_enable);
   end

   // ----------------------------------------------------------------
   // Line output
   // ----------------------------------------------------------------
   // Off, the line rests at its idle level so no glitch reaches the receiver.
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         tx_o <= 1'b1;
      else if (port_live)
         tx_o <= line ^ polarity_invert;
      else
         tx_o <= !polarity_invert;
   end

   // ----------------------------------------------------------------
   // Rate generator and shifter
   // ----------------------------------------------------------------
   baud_tick_gen u_rate
   (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .restart_i(transfer),
      .wide_i(wide_divisor_select),
      .divisor_i(wide_divisor_select ? {rate_divisor_high, rate_divisor_low}
         : {8'h00, rate_divisor_low}),
      .tick_o(tick)
   );

   tx_frame_shifter u_shift
   (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .load_i(transfer),
      .data_i(load_word),
      .nine_i(nine_bit_enable),
      .tick_i(tick),
      .line_o(line),
      .busy_o(sh_busy),
      .done_o(sh_done)
   );

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   chk_empty_clears: assert property (transfer |=> !shifter_empty_flag)
      else $error("empty flag not cleared by transfer");
   chk_empty_holds: assert property ($rose(shifter_empty_flag) |-> $past(sh_done))
      else $error("empty flag set before frame end");
   chk_empty_readonly: assert property (wr_byte && adr_i == TSC_OFS && sh_busy
      && dat_i[TSC_EMPTY] |=> !shifter_empty_flag)
      else $error("empty flag written by software");
   chk_nine_word: assert property (transfer |=> u_shift.transmit_shifter ==
      {$past(nine_bit_enable && ninth_data_value), $past(transmit_holding_reg)})
      else $error("ninth bit wrong at transfer");
   chk_move_prompt: assert property (holding_full && !sh_busy && tx_run
      |=> !holding_full && sh_busy)
      else $error("waiting character not moved");
   chk_idle_off: assert property (!port_live |=> tx_o == !$past(polarity_invert))
      else $error("line not idle while port off");
   chk_invert: assert property (port_live |=> tx_o == ($past(line) ^ $past(polarity_invert)))
      else $error("line polarity wrong");
   chk_transmit_enable_bit_flag: assert property ($rose(transmit_enable_bit) && !holding_full
      |-> tx_buffer_flag)
      else $error("buffer flag not set by enable");
   chk_irq_level: assert property (tx_buffer_flag && irq_enable[IRQ_BUF]
      && global_interrupt_enable && peripheral_interrupt_enable |=> irq_o)
      else $error("interrupt missing");
   chk_write_starts: assert property (wr_byte && adr_i == HOLD_OFS && tx_run
      && !holding_full |=> holding_full ##1 sh_busy)
      else $error("holding write did not start a frame");
   chk_start_bit: assert property (transfer |=> !line [*2])
      else $error("start bit missing");
   chk_flag_clear: assert property (holding_full |-> !tx_buffer_flag)
      else $error("buffer flag set while holding full");

   cov_nine_frame: cover property (sh_done && nine_bit_enable);
   cov_inverted: cover property (port_live && polarity_invert && transfer);
   cov_irq: cover property ($rose(irq_o));
endmodule // async_serial_transmitter

// [serial_line_receiver.sv]
/*
   Behavioural remote receiver for the serial transmit line.
   Assumes the bench sets bit period, polarity and width while disarmed.
*/
`timescale 1ns/1ps
module serial_line_receiver
(
   input wire logic clk_i,
   input wire logic arm_i,
   input wire logic inv_i,
   input wire logic nine_i,
   input wire logic [15:0] bit_cycles_i,
   input wire logic line_i,
   output logic [8:0] data_o,
   output logic stop_ok_o,
   output logic got_o
);
   logic [8:0] acc;
   int k;

   initial
   begin
      data_o = 9'h000;
      stop_ok_o = 1'b0;
      got_o = 1'b0;
   end

   // ----------------------------------------------------------------
   // Frame capture
   // ----------------------------------------------------------------
   // Hunt for a start bit, then sample every bit in its middle.
   // Disarming during setup keeps a polarity change from looking like a start.
   always
   begin
      @(posedge clk_i);
      got_o <= 1'b0;
      if (arm_i === 1'b1 && (line_i_lvl()) === 1'b0)
      begin
         acc = 9'h000;
         repeat (bit_cycles_i / 2) @(posedge clk_i);
         for (k = 0; k < (nine_i ? 9 : 8); k++)
         begin
            repeat (bit_cycles_i) @(posedge clk_i);
            acc[k] = line_i_lvl();
         end
         repeat (bit_cycles_i) @(posedge clk_i);
         stop_ok_o <= (line_i_lvl() === 1'b1);
         data_o <= acc;
         got_o <= 1'b1;
      end
   end

   // Line level as a receiver of normal polarity would see it.
   function automatic logic line_i_lvl();
      return line_i ^ inv_i;
   endfunction
endmodule // serial_line_receiver

// [async_serial_transmitter_tb_top.sv]
/*
   Self-checking bench for the serial transmitter: Wishbone register traffic,
   frames caught by a line receiver model, interrupt checks.
   Assumes the design acks every request and the receiver is told the rate.
*/
`timescale 1ns/1ps
module async_serial_transmitter_tb_top
   import uart_tx_pkg::*;
;
   // ----------------------------------------------------------------
   // Signals
   // ----------------------------------------------------------------
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic cyc_i = 1'b0;
   logic stb_i = 1'b0;
   logic we_i = 1'b0;
   logic [ADDR_W-1:0] adr_i = 6'h00;
   logic [3:0] sel_i = 4'hF;
   logic [31:0] dat_i = 32'h0;
   logic [31:0] dat_o;
   logic ack_o;
   logic tx_o;
   logic irq_o;
   logic rx_arm = 1'b0;
   logic rx_inv = 1'b0;
   logic rx_nine = 1'b0;
   logic [15:0] rx_bits = 16'h0040;
   logic [8:0] rx_data;
   logic rx_stop;
   logic rx_got;
   logic [31:0] rd;
   logic [8:0] ch;
   logic [8:0] ch2;
   logic moved;
   logic [7:0] port_v [3] = '{8'h80, 8'h80, 8'h98};
   logic [7:0] tsc_v [3] = '{8'h20, 8'h60, 8'h60};
   logic [7:0] div_v [3] = '{8'h00, 8'h01, 8'h02};
   int error_cnt = 0;
   int samples_checked = 0;
   int c;

   always #2.5 clk_i = ~clk_i;

   async_serial_transmitter uut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
      .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
      .tx_o(tx_o), .irq_o(irq_o));
   serial_line_receiver rx (.clk_i(clk_i), .arm_i(rx_arm), .inv_i(rx_inv), .nine_i(rx_nine),
      .bit_cycles_i(rx_bits), .line_i(tx_o), .data_o(rx_data), .stop_ok_o(rx_stop),
      .got_o(rx_got));

   // ----------------------------------------------------------------
   // Tasks
   // ----------------------------------------------------------------
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("ERROR at %0t got %h expected %h", $time, got, exp);
      end
   endtask

   // One classic cycle; the request holds until ack is sampled high.
   task automatic wb(input logic w, input logic [5:0] a, input logic [31:0] d);
      @(posedge clk_i);
      cyc_i <= 1'b1;
      stb_i <= 1'b1;
      we_i <= w;
      sel_i <= 4'hF;
      adr_i <= a;
      dat_i <= d;
      @(posedge clk_i);
      while (ack_o !== 1'b1) @(posedge clk_i);
      rd = dat_o;
      cyc_i <= 1'b0;
      stb_i <= 1'b0;
   endtask

   task automatic rd_chk(input logic [5:0] a, input logic [31:0] m, input logic [31:0] e);
      wb(1'b0, a, 32'h0);
      check(rd & m, e);
   endtask

   // Two edges first, so a pulse already seen is not counted twice.
   task automatic wait_rx(input logic [8:0] exp);
      int i;
      repeat (2) @(posedge clk_i);
      for (i = 0; i < 4000 && rx_got !== 1'b1; i++) @(posedge clk_i);
      check({22'h0, rx_got, rx_stop, rx_data}, {22'h0, 2'b11, exp});
   endtask

   function automatic logic [15:0] bit_len(input logic [7:0] port, input logic [7:0] dv);
      return 16'((port[PORT_WIDE] ? PRE_WIDE : PRE_NARROW) * (int'(dv) + 1));
   endfunction

   task automatic close_out;
      $display("checks %0d mismatches %0d", samples_checked, error_cnt);
      if (error_cnt == 0 && samples_checked > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   initial
   begin
      repeat (30000) @(posedge clk_i);
      error_cnt++;
      close_out();
   end

   // ----------------------------------------------------------------
   // Sequence
   // ----------------------------------------------------------------
   initial
   begin
      void'($urandom(32'hc197));
      repeat (20) @(posedge clk_i);
      rst_i <= 1'b0;
      check({30'h0, tx_o, irq_o}, 32'h2);
      rd_chk(TSC_OFS, 32'hFF, 32'h2);
      rd_chk(HOLD_OFS, 32'hFFFFFFFF, 32'h0);
      rd_chk(6'h24, 32'hFFFFFFFF, 32'h0);
      rd_chk(DIVL_OFS, 32'hFF, {24'h0, DIV_RESET});
      rd_chk(IRQ_STAT_OFS, 32'h3, 32'h0);
      $display("reset test done");
      wb(1'b1, PORT_OFS, 32'h80);
      wb(1'b1, TSC_OFS, 32'h20);
      rd_chk(IRQ_STAT_OFS, 32'h1, 32'h1);
      wb(1'b1, IRQ_EN_OFS, 32'h1);
      wb(1'b1, INTC_OFS, 32'h40);
      rd_chk(INTC_OFS, 32'hC0, 32'h40);
      check({31'h0, irq_o}, 32'h0);
      wb(1'b1, INTC_OFS, 32'hC0);
      rd_chk(INTC_OFS, 32'hC0, 32'hC0);
      check({31'h0, irq_o}, 32'h1);
      $display("interrupt test done");
      // Rate, width and polarity from the table, one random character each.
      for (c = 0; c < 3; c++)
      begin
         rx_arm <= 1'b0;
         ch = {(c != 0) & 1'($urandom), 8'($urandom)};
         wb(1'b1, DIVL_OFS, {24'h0, div_v[c]});
         wb(1'b1, DIVH_OFS, 32'h0);
         wb(1'b1, PORT_OFS, {24'h0, port_v[c]});
         wb(1'b1, TSC_OFS, {24'h0, tsc_v[c] | {7'h0, ch[8]}});
         rd_chk(PORT_OFS, 32'hFF, {24'h0, port_v[c]});
         repeat (4) @(posedge clk_i);
         rx_inv <= port_v[c][PORT_INV];
         rx_nine <= tsc_v[c][TSC_NINE];
         rx_bits <= bit_len(port_v[c], div_v[c]);
         @(posedge clk_i);
         rx_arm <= 1'b1;
         wb(1'b1, HOLD_OFS, {24'h0, ch[7:0]});
         rd_chk(IRQ_STAT_OFS, 32'h1, 32'h1);
         // Software tries to set the read-only empty bit while the frame runs.
         wb(1'b1, TSC_OFS, {24'h0, tsc_v[c] | {7'h0, ch[8]} | 8'h02});
         rd_chk(TSC_OFS, 32'h2, 32'h0);
         wait_rx(ch);
         rd_chk(TSC_OFS, 32'h2, 32'h0);
         repeat (bit_len(port_v[c], div_v[c])) @(posedge clk_i);
         rd_chk(TSC_OFS, 32'h2, 32'h2);
         $display("frame test %0d done", c);
      end
      // Second character waits in the holding register behind the first.
      ch2 = {ch[8], 8'($urandom)};
      ch = {ch[8], 8'($urandom)};
      wb(1'b1, HOLD_OFS, {24'h0, ch[7:0]});
      wb(1'b1, HOLD_OFS, {24'h0, ch2[7:0]});
      rd_chk(IRQ_STAT_OFS, 32'h1, 32'h0);
      check({31'h0, irq_o}, 32'h0);
      wait_rx(ch);
      wait_rx(ch2);
      rd_chk(IRQ_STAT_OFS, 32'h2, 32'h2);
      wb(1'b1, IRQ_CLR_OFS, 32'h2);
      rd_chk(IRQ_STAT_OFS, 32'h2, 32'h0);
      $display("back to back test done");
      // Clocked mode, then a disabled port: a holding write must stay silent.
      rx_arm <= 1'b0;
      for (c = 0; c < 2; c++)
      begin
         wb(1'b1, TSC_OFS, (c == 0) ? 32'h30 : 32'h20);
         wb(1'b1, PORT_OFS, (c == 0) ? 32'h80 : 32'h00);
         repeat (4) @(posedge clk_i);
         ch[0] = tx_o;
         moved = 1'b0;
         wb(1'b1, HOLD_OFS, 32'h55);
         repeat (1000)
         begin
            @(posedge clk_i);
            moved = moved | (tx_o !== ch[0]);
         end
         check({31'h0, moved}, 32'h0);
         rd_chk(TSC_OFS, 32'h2, 32'h2);
      end
      $display("disable test done");
      close_out();
   end
endmodule // async_serial_transmitter_tb_top
